// *** hw/cdb_core_debug.sv ***
// Core debug unit: cycle counter, profiling sample, breakpoints and emulation entry
//
// Contract
// RULE1: 32-bit cycle counter counts each clock in user space, holds when halted.
// RULE2: 32-bit extension counts each wrap of the cycle counter.
// RULE3: Cycle registers written only in emulation space, readable from user space.
// RULE4: 24-bit sampled PC captures the PC on every debug access.
// RULE5: Breakpoint mode bit 25 gives the core breakpoint control, else emulator only.
// RULE6: With mode bit set, user space may write all range registers.
// RULE7: Core sees breakpoint status only with mode bit set; shows which hit.
// RULE8: Return from interrupt clears all breakpoint status bits.
// RULE9: Single step suppresses breakpoint status updates for user breakpoints.
// RULE10: User hardware breakpoint raises the level 12 breakpoint interrupt.
// RULE11: Halt request or emulation breakpoint raises the level 0 emulator interrupt.
// RULE12: Single step runs one instruction, re-enters emulation, flushes on resume.
// RULE13: Emulator interrupt pushes PC, vectors to reset, idles for emulator instruction.
// RULE14: Emulation space stops timer and counter, disables cache, optionally stalls DMA.
// RULE15: Emulation space sets the stopped flag in run control status.
// RULE16: In emulation space hold per scanned instruction, PC not incremented.
// RULE17: Instruction and program memory negate changes act four clocks later.
// RULE18: During boot load the pipeline gets idle until the boot interrupt.
// RULE19: Emulator loads instruction over the link; core executes it from there.
// RULE20: Software sets up interrupt, mode, count, ranges, conditions, then AND.
// RULE21: Event counter decrements per breakpoint; interrupt when event meets zero.
// RULE22: Range match is inclusive; start above end disables the breakpoint.
// RULE23: OR within groups, enabled groups combined by AND or OR select.
// RULE24: Extension increments in the same cycle as the counter wraps.
`timescale 1ns/1ps
module cdb_core_debug
  import cdb_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic tck,
  input wire cdb_req_t jtagReq,
  output cdb_link_st_t jtagState,
  output logic [CDB_DW-1:0] jtagRdata,
  output logic jtagDone,
  output logic jtagBusy,
  input wire cdb_req_t coreReq,
  output logic [CDB_DW-1:0] coreRdata,
  input wire logic [CDB_PCW-1:0] pc,
  input wire cdb_bus_addr_t iaBus,
  input wire cdb_bus_addr_t daBus,
  input wire cdb_bus_addr_t paBus,
  input wire logic abortExec,
  input wire logic instrRetired,
  input wire logic rtiExec,
  input wire logic bootStart,
  input wire logic bootIrq,
  output cdb_irq_t irq,
  output cdb_core_ctl_t ctl,
  output logic [CDB_DW-1:0] emuInstr,
  output logic emuInstrValid
);
  cdb_core_st_t cr;
  cdb_core_st_t next_cr;
  cdb_link_st_t jr;
  cdb_link_st_t next_jr;
  logic [CDB_NBP-1:0] hit;
  logic [CDB_NBP-1:0] negEff;
  logic grpIa;
  logic grpDa;
  logic grpPa;
  logic [2:0] grpEn;
  logic bpEvent;

  // Link side: one request in flight, data held stable while busy
  always_comb
  begin
    next_jr = jr;
    next_jr.done = 1'b0;
    next_jr.ackS1 = cr.ackTgl;
    next_jr.ackS2 = jr.ackS1;
    // Done cycle still shows the finished request
    if (jtagReq.sel && !jr.busy && !jr.done)
    begin
      next_jr.req = jtagReq;
      next_jr.reqTgl = ~jr.reqTgl;
      next_jr.busy = 1'b1;
    end
    if (jr.ackS2 != jr.ackSeen)
    begin
      next_jr.ackSeen = jr.ackS2;
      next_jr.rdata = cr.jRdata;
      next_jr.done = 1'b1;
      next_jr.busy = 1'b0;
    end
  end

  always_ff @(posedge tck or negedge rstn)
  begin
    if (!rstn)
      jr <= '0;
    else
      jr <= next_jr;
  end

  assign jtagState = jr;
  assign jtagRdata = jr.rdata;
  assign jtagDone = jr.done;
  assign jtagBusy = jr.busy;

  // Breakpoint comparators
  // RULE17: delayed negate mask
  assign negEff = (cr.negPipe[CDB_NEG_LAT-1] & CDB_NEG_DELAYED)
    | (cr.ctrl[CDB_NEG_LSB +: CDB_NBP] & ~CDB_NEG_DELAYED);
  generate
    for (genvar i = 0; i < CDB_NBP; i++)
    begin : gBp
      cdb_bus_addr_t src;
      logic inRange;
      assign src = (i < 4) ? iaBus : ((i < 6) ? daBus : paBus);
      assign inRange = (src.addr >= cr.bpStart[i]) && (src.addr <= cr.bpEnd[i]);
      // RULE22: inclusive range
      assign hit[i] = src.valid && !abortExec && (cr.bpStart[i] <= cr.bpEnd[i]) && (inRange ^ negEff[i]);
    end
  endgenerate

  // RULE23: group OR then AND or OR
  assign grpIa = |hit[3:0];
  assign grpDa = |hit[5:4];
  assign grpPa = hit[6];
  assign grpEn = {cr.ctrl[CDB_EN_PA_BIT], cr.ctrl[CDB_EN_DA_BIT], cr.ctrl[CDB_EN_IA_BIT]};
  assign bpEvent = (cr.state == CDB_RUN) && (cr.ctrl[CDB_AND_BIT]
    ? ((&({grpPa, grpDa, grpIa} | ~grpEn)) && (|grpEn))
    : (|({grpPa, grpDa, grpIa} & grpEn)));

  function automatic logic [CDB_DW-1:0] readReg(input cdb_core_st_t s, input logic [CDB_AW-1:0] a,
                                                input logic fromCore);
    logic [CDB_DW-1:0] v;
    v = CDB_ZERO;
    if (a == CDB_A_CYC)
      v = s.cyc;
    else if (a == CDB_A_CYCEXT)
      v = s.cycExt;
    else if (a == CDB_A_SPC)
      v = {{(CDB_DW-CDB_PCW){1'b0}}, s.spc};
    else if (a == CDB_A_BRKCTL)
      v = s.ctrl;
    // RULE7: status hidden from core without mode bit
    else if (a == CDB_A_BRKSTAT && (!fromCore || s.ctrl[CDB_USER_BREAKPOINT_MODE_BIT]))
      v = {{(CDB_DW-CDB_NBP){1'b0}}, s.stat};
    else if (a == CDB_A_EVCNT)
      v = s.evCnt;
    else if (a == CDB_A_RCS)
      v = s.run_control_status_register;
    else if (a == CDB_A_EMUINSTR)
      v = s.emuInstr;
    else if (a >= CDB_A_BP_BASE && a <= CDB_A_BP_LAST)
      v = a[0] ? s.bpEnd[(a - CDB_A_BP_BASE) >> 1] : s.bpStart[(a - CDB_A_BP_BASE) >> 1];
    return v;
  endfunction : readReg

  always_comb
  begin
    cdb_req_t w [2];
    logic jAcc;
    logic [CDB_AW-1:0] bpOff;
    jAcc = 1'b0;
    bpOff = '0;
    w[0] = coreReq;
    next_cr = cr;
    next_cr.reqS1 = jr.reqTgl;
    next_cr.reqS2 = cr.reqS1;
    next_cr.irq = '0;
    next_cr.emuInstrValid = 1'b0;
    next_cr.ctl.flushPipe = 1'b0;
    next_cr.negPipe = {cr.negPipe[CDB_NEG_LAT-2:0], cr.ctrl[CDB_NEG_LSB +: CDB_NBP]};
    jAcc = cr.reqS2 != cr.reqSeen;
    w[1] = jr.req;
    w[1].sel = jAcc;

    // RULE1: count only while user code runs
    // RULE14: counter stopped outside user space
    if (cr.state == CDB_RUN)
    begin
      next_cr.cyc = cr.cyc + 32'h00000001;
      // RULE2: extension on wrap
      // RULE24: same-cycle carry
      if (&cr.cyc)
        next_cr.cycExt = cr.cycExt + 32'h00000001;
    end

    // RULE8: clear on return from interrupt
    if (rtiExec && cr.state == CDB_RUN)
      next_cr.stat = '0;

    // RULE5: breakpoint ownership by mode bit
    if (bpEvent && cr.ctrl[CDB_USER_BREAKPOINT_MODE_BIT])
    begin
      // RULE9: no status in single step
      if (!cr.run_control_status_register[CDB_RCS_SSTEP])
        next_cr.stat = next_cr.stat | hit;
      // RULE21: Nth event counting
      if (cr.evCnt == CDB_ZERO)
      begin
        // RULE10: low priority breakpoint interrupt
        next_cr.irq.bkptIrq = 1'b1;
        next_cr.irq.level = CDB_IVT_BKPT;
      end
      else
        next_cr.evCnt = cr.evCnt - 32'h00000001;
    end

    // Core then link writes; link wins on the same register
    for (int s = 0; s < 2; s++)
    begin
      if (w[s].sel && w[s].write)
      begin
        bpOff = w[s].addr - CDB_A_BP_BASE;
        // RULE3: cycle registers only in emulation space
        if (w[s].addr == CDB_A_CYC && cr.state == CDB_HALT)
          next_cr.cyc = w[s].wdata;
        else if (w[s].addr == CDB_A_CYCEXT && cr.state == CDB_HALT)
          next_cr.cycExt = w[s].wdata;
        else if (w[s].addr == CDB_A_BRKCTL)
          next_cr.ctrl = w[s].wdata;
        else if (w[s].addr == CDB_A_EVCNT)
          next_cr.evCnt = w[s].wdata;
        else if (w[s].addr == CDB_A_RCS && s == 1)
          next_cr.run_control_status_register = (cr.run_control_status_register & ~CDB_RCS_WMASK) | (w[s].wdata & CDB_RCS_WMASK);
        // RULE19: instruction loaded over the link
        else if (w[s].addr == CDB_A_EMUINSTR && s == 1 && cr.state == CDB_HALT)
        begin
          next_cr.emuInstr = w[s].wdata;
          next_cr.emuInstrValid = 1'b1;
        end
        // RULE6: user writes to ranges need mode bit
        else if (w[s].addr >= CDB_A_BP_BASE && w[s].addr <= CDB_A_BP_LAST
                 && (s == 1 || cr.ctrl[CDB_USER_BREAKPOINT_MODE_BIT] || cr.state == CDB_HALT))
        begin
          if (bpOff[0])
            next_cr.bpEnd[bpOff[CDB_AW-1:1]] = w[s].wdata;
          else
            next_cr.bpStart[bpOff[CDB_AW-1:1]] = w[s].wdata;
        end
      end
    end

    if (coreReq.sel && !coreReq.write)
      next_cr.coreRdata = readReg(cr, coreReq.addr, 1'b1);
    if (jAcc)
    begin
      // RULE4: sample PC on every link access
      next_cr.spc = pc;
      next_cr.reqSeen = cr.reqS2;
      next_cr.ackTgl = ~cr.ackTgl;
      next_cr.jRdata = readReg(cr, jr.req.addr, 1'b0);
    end

    if (instrRetired && cr.state == CDB_RUN)
      next_cr.stepDone = 1'b1;

    unique case (cr.state)
      CDB_RUN:
      begin
        // RULE11: halt request or emulation breakpoint
        // RULE12: one instruction then back to emulation
        if (cr.run_control_status_register[CDB_RCS_HALT] || (bpEvent && !cr.ctrl[CDB_USER_BREAKPOINT_MODE_BIT])
            || (cr.run_control_status_register[CDB_RCS_SSTEP] && cr.stepDone))
        begin
          next_cr.state = CDB_ENTER;
          next_cr.run_control_status_register[CDB_RCS_HALT] = 1'b0;
          next_cr.irq.emuIrq = 1'b1;
          next_cr.irq.level = CDB_IVT_EMU;
        end
      end
      CDB_ENTER:
      begin
        next_cr.state = CDB_HALT;
        // RULE15: stopped flag on entry
        next_cr.run_control_status_register[CDB_RCS_STOPPED] = 1'b1;
      end
      CDB_HALT:
      begin
        if (rtiExec)
        begin
          next_cr.state = CDB_RUN;
          next_cr.stepDone = 1'b0;
          next_cr.run_control_status_register[CDB_RCS_STOPPED] = 1'b0;
          // RULE12: flush on each resume from single step
          next_cr.ctl.flushPipe = cr.run_control_status_register[CDB_RCS_SSTEP];
        end
      end
    endcase

    // RULE13: push and vector on entry
    next_cr.ctl.pcPush = next_cr.state == CDB_ENTER;
    next_cr.ctl.vectorReset = next_cr.state == CDB_ENTER;
    next_cr.ctl.emuSpace = next_cr.state != CDB_RUN;
    // RULE16: PC holds while instructions are scanned
    next_cr.ctl.pcHold = next_cr.state == CDB_HALT;
    next_cr.ctl.fetchFromEmu = next_cr.state == CDB_HALT;
    // RULE14: timer, cache and optional DMA stall
    next_cr.ctl.timerStop = next_cr.state != CDB_RUN;
    next_cr.ctl.cacheDisable = next_cr.state != CDB_RUN;
    next_cr.ctl.dmaStall = (next_cr.state != CDB_RUN) && next_cr.run_control_status_register[CDB_RCS_DMASTALL];

    // RULE18: idle feed until boot interrupt
    if (bootStart)
      next_cr.bootWait = 1'b1;
    if (bootIrq)
      next_cr.bootWait = 1'b0;
    next_cr.ctl.feedIdle = next_cr.bootWait;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      cr <= '0;
    else
      cr <= next_cr;
  end

  assign coreRdata = cr.coreRdata;
  assign irq = cr.irq;
  assign ctl = cr.ctl;
  assign emuInstr = cr.emuInstr;
  assign emuInstrValid = cr.emuInstrValid;

  // Checks
  cyc_count_run_a: assert property (@(posedge clock) disable iff (!rstn) // RULE1
    cr.state == CDB_RUN |=> cr.cyc == $past(cr.cyc) + 32'h00000001)
    else $error("cycle counter did not advance in user space");
  cyc_ext_wrap_a: assert property (@(posedge clock) disable iff (!rstn) // RULE24
    (cr.state == CDB_RUN && (&cr.cyc)) |=> cr.cyc == CDB_ZERO && cr.cycExt == $past(cr.cycExt) + 32'h00000001)
    else $error("extension missed the wrap cycle");
  cyc_hold_a: assert property (@(posedge clock) disable iff (!rstn) // RULE14
    (cr.state == CDB_ENTER) |=> $stable(cr.cyc) && $stable(cr.cycExt))
    else $error("cycle registers moved outside user space");
  pc_sample_a: assert property (@(posedge clock) disable iff (!rstn) // RULE4
    (cr.reqS2 != cr.reqSeen) |=> cr.spc == $past(pc) && cr.ackTgl != $past(cr.ackTgl))
    else $error("sampled pc not captured on link access");
  stat_hidden_a: assert property (@(posedge clock) disable iff (!rstn) // RULE7
    (coreReq.sel && !coreReq.write && coreReq.addr == CDB_A_BRKSTAT && !cr.ctrl[CDB_USER_BREAKPOINT_MODE_BIT])
    |=> coreRdata == CDB_ZERO)
    else $error("status visible without mode bit");
  stat_rti_clear_a: assert property (@(posedge clock) disable iff (!rstn) // RULE8
    (rtiExec && cr.state == CDB_RUN && !bpEvent) |=> cr.stat == '0)
    else $error("status not cleared by return");
  step_no_stat_a: assert property (@(posedge clock) disable iff (!rstn) // RULE9
    (cr.run_control_status_register[CDB_RCS_SSTEP] && !rtiExec) |=> $stable(cr.stat))
    else $error("status updated in single step");
  bkpt_zero_a: assert property (@(posedge clock) disable iff (!rstn) // RULE21
    irq.bkptIrq |-> $past(cr.evCnt) == CDB_ZERO && irq.level == CDB_IVT_BKPT)
    else $error("breakpoint interrupt without zero count");
  emu_entry_a: assert property (@(posedge clock) disable iff (!rstn) // RULE13
    irq.emuIrq |-> ctl.pcPush && ctl.vectorReset ##1 cr.state == CDB_HALT && ctl.pcHold)
    else $error("emulation entry sequence broken");
  halted_flag_a: assert property (@(posedge clock) disable iff (!rstn) // RULE15
    cr.state == CDB_HALT |-> cr.run_control_status_register[CDB_RCS_STOPPED] && ctl.timerStop && ctl.cacheDisable)
    else $error("halted state without stopped flag");
  neg_latency_a: assert property (@(posedge clock) disable iff (!rstn) // RULE17
    cr.negPipe[CDB_NEG_LAT-1] == $past(cr.ctrl[CDB_NEG_LSB +: CDB_NBP], 4))
    else $error("negate latency not four cycles");
  halt_entry_a: assert property (@(posedge clock) disable iff (!rstn) // RULE11
    (cr.state == CDB_RUN && cr.run_control_status_register[CDB_RCS_HALT]) |=> irq.emuIrq && irq.level == CDB_IVT_EMU)
    else $error("halt request did not raise emulator interrupt");
  step_flush_a: assert property (@(posedge clock) disable iff (!rstn) // RULE12
    (rtiExec && cr.state == CDB_HALT && cr.run_control_status_register[CDB_RCS_SSTEP]) |=> ctl.flushPipe)
    else $error("no pipeline flush on single step resume");
  scan_hold_a: assert property (@(posedge clock) disable iff (!rstn) // RULE16
    ctl.pcHold |-> ctl.fetchFromEmu && ctl.emuSpace && !ctl.pcPush)
    else $error("pc hold without emulation fetch");
  boot_release_a: assert property (@(posedge clock) disable iff (!rstn) // RULE18
    bootIrq |=> !ctl.feedIdle)
    else $error("idle feed outlived boot interrupt");
  // Link side must not take the held request twice
  link_done_idle_a: assert property (@(posedge tck) disable iff (!rstn) // RULE19
    jr.done |=> !jr.busy)
    else $error("link request taken again in done cycle");
endmodule : cdb_core_debug

// *** hw/cdb_pkg.sv ***
// Shared constants, carriers and state types of the core debug block
package cdb_pkg;
  localparam int CDB_AW = 8;
  localparam int CDB_DW = 32;
  localparam int CDB_PCW = 24;
  localparam int CDB_NBP = 7;
  localparam int CDB_NEG_LAT = 4;
  localparam int CDB_BOOT_WORDS = 256;
  localparam logic [CDB_AW-1:0] CDB_A_CYC = 8'h00;
  localparam logic [CDB_AW-1:0] CDB_A_CYCEXT = 8'h01;
  localparam logic [CDB_AW-1:0] CDB_A_SPC = 8'h02;
  localparam logic [CDB_AW-1:0] CDB_A_BRKCTL = 8'h03;
  localparam logic [CDB_AW-1:0] CDB_A_BRKSTAT = 8'h04;
  localparam logic [CDB_AW-1:0] CDB_A_EVCNT = 8'h05;
  localparam logic [CDB_AW-1:0] CDB_A_RCS = 8'h06;
  localparam logic [CDB_AW-1:0] CDB_A_EMUINSTR = 8'h07;
  localparam logic [CDB_AW-1:0] CDB_A_BP_BASE = 8'h10;
  localparam logic [CDB_AW-1:0] CDB_A_BP_LAST = 8'h1D;
  localparam int CDB_USER_BREAKPOINT_MODE_BIT = 25;
  localparam int CDB_EN_IA_BIT = 0;
  localparam int CDB_EN_DA_BIT = 1;
  localparam int CDB_EN_PA_BIT = 2;
  localparam int CDB_AND_BIT = 3;
  localparam int CDB_NEG_LSB = 4;
  localparam logic [CDB_NBP-1:0] CDB_NEG_DELAYED = 7'h4F;
  localparam int CDB_RCS_HALT = 0;
  localparam int CDB_RCS_STOPPED = 1;
  localparam int CDB_RCS_SSTEP = 2;
  localparam int CDB_RCS_DMASTALL = 3;
  localparam logic [CDB_DW-1:0] CDB_RCS_WMASK = 32'h0000000D;
  localparam logic [3:0] CDB_IVT_EMU = 4'h0;
  localparam logic [3:0] CDB_IVT_BKPT = 4'hC;
  localparam logic [CDB_DW-1:0] CDB_ZERO = 32'h00000000;

  typedef struct packed {
    logic sel;
    logic write;
    logic [CDB_AW-1:0] addr;
    logic [CDB_DW-1:0] wdata;
  } cdb_req_t;

  typedef struct packed {
    logic valid;
    logic [CDB_DW-1:0] addr;
  } cdb_bus_addr_t;

  typedef struct packed {
    logic emuIrq;
    logic bkptIrq;
    logic [3:0] level;
  } cdb_irq_t;

  typedef struct packed {
    logic pcPush;
    logic vectorReset;
    logic emuSpace;
    logic pcHold;
    logic fetchFromEmu;
    logic timerStop;
    logic cacheDisable;
    logic dmaStall;
    logic flushPipe;
    logic feedIdle;
  } cdb_core_ctl_t;

  typedef enum logic [1:0] {CDB_RUN, CDB_ENTER, CDB_HALT} cdb_state_t;

  typedef struct packed {
    cdb_state_t state;
    logic [CDB_DW-1:0] cyc;
    logic [CDB_DW-1:0] cycExt;
    logic [CDB_PCW-1:0] spc;
    logic [CDB_DW-1:0] ctrl;
    logic [CDB_NBP-1:0] stat;
    logic [CDB_DW-1:0] evCnt;
    logic [CDB_DW-1:0] run_control_status_register;
    logic [CDB_NBP-1:0][CDB_DW-1:0] bpStart;
    logic [CDB_NBP-1:0][CDB_DW-1:0] bpEnd;
    logic [CDB_NEG_LAT-1:0][CDB_NBP-1:0] negPipe;
    logic bootWait;
    logic stepDone;
    logic reqS1;
    logic reqS2;
    logic reqSeen;
    logic ackTgl;
    logic [CDB_DW-1:0] jRdata;
    logic [CDB_DW-1:0] coreRdata;
    logic [CDB_DW-1:0] emuInstr;
    logic emuInstrValid;
    cdb_irq_t irq;
    cdb_core_ctl_t ctl;
  } cdb_core_st_t;

  typedef struct packed {
    logic reqTgl;
    logic busy;
    cdb_req_t req;
    logic ackS1;
    logic ackS2;
    logic ackSeen;
    logic [CDB_DW-1:0] rdata;
    logic done;
  } cdb_link_st_t;
endpackage : cdb_pkg

// *** bench/cdb_emu_probe.sv ***
// Emulator probe model driving the link side
`timescale 1ns/1ps
module cdb_emu_probe
  import cdb_pkg::*;
(
  output logic tck,
  output cdb_req_t jtagReq,
  input wire logic [CDB_DW-1:0] jtagRdata,
  input wire logic jtagDone
);
  logic run;
  initial
  begin
    tck = 1'b0;
    jtagReq = '0;
    run = 1'b1;
    #400 run = 1'b0;
  end
  // Link clock runs for the first 400 ns and inside frames
  always #16 if (run) tck = ~tck;
  task automatic xfer(input logic w, input logic [CDB_AW-1:0] a, input logic [CDB_DW-1:0] d,
    output logic [CDB_DW-1:0] r, output logic ok);
    ok = 1'b0;
    r = '0;
    run = 1'b1;
    @(posedge tck);
    #1 jtagReq = '{1'b1, w, a, d};
    for (int i = 0; i < 40 && !ok; i++)
    begin
      @(posedge tck);
      if (jtagDone === 1'b1)
      begin
        ok = 1'b1;
        r = jtagRdata;
      end
    end
    // Released lines show the inverse
    #1 jtagReq = '{1'b0, 1'b0, ~a, ~d};
    @(posedge tck);
    @(posedge tck);
    run = 1'b0;
  endtask : xfer
endmodule : cdb_emu_probe

// *** bench/tb_top.sv ***
// Self-checking bench for the core debug unit
`timescale 1ns/1ps
module tb_top
  import cdb_pkg::*;
;
  typedef struct {logic w; logic [CDB_AW-1:0] a; logic [CDB_DW-1:0] d;} cdb_row_t;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic tck;
  cdb_req_t jtagReq;
  logic [CDB_DW-1:0] jtagRdata;
  logic jtagDone;
  logic jtagBusy;
  cdb_req_t coreReq = '0;
  logic [CDB_DW-1:0] coreRdata;
  logic [CDB_PCW-1:0] pc = 24'h3C5A96;
  cdb_bus_addr_t daBus = '0;
  logic instrRetired = 1'b0;
  logic rtiExec = 1'b0;
  logic bootStart = 1'b0;
  logic bootIrq = 1'b0;
  logic abortExec = 1'b0;
  cdb_irq_t irq;
  cdb_core_ctl_t ctl;
  logic [CDB_DW-1:0] emuInstr;
  logic emuInstrValid;
  logic [CDB_DW-1:0] rd;
  logic [CDB_DW-1:0] r1;
  logic ok;
  int fails = 0;
  int cmp_count = 0;
  int emuCnt = 0;
  int bkptCnt = 0;
  int flushCnt = 0;
  logic [3:0] lvl = 4'hF;
  logic [CDB_DW-1:0] gotInstr = '0;
  cdb_row_t rows [10] = '{
    '{1'b1, CDB_A_BRKCTL, 32'h02000000}, '{1'b0, CDB_A_BRKCTL, 32'h02000000},
    '{1'b1, CDB_A_EVCNT, 32'h00000000}, '{1'b1, 8'h18, 32'h00000100},
    '{1'b1, 8'h19, 32'h000001FF}, '{1'b0, 8'h18, 32'h00000100},
    '{1'b0, 8'h19, 32'h000001FF}, '{1'b1, CDB_A_BRKCTL, 32'h02000002},
    '{1'b0, CDB_A_BRKSTAT, 32'h00000000}, '{1'b0, 8'h08, 32'h00000000}};

  always #12.5 clock = ~clock;

  cdb_emu_probe probe (.tck(tck), .jtagReq(jtagReq), .jtagRdata(jtagRdata), .jtagDone(jtagDone));

  cdb_core_debug uut (.clock(clock), .rstn(rstn), .tck(tck), .jtagReq(jtagReq), .jtagState(),
    .jtagRdata(jtagRdata), .jtagDone(jtagDone), .jtagBusy(jtagBusy), .coreReq(coreReq),
    .coreRdata(coreRdata), .pc(pc), .iaBus('0), .daBus(daBus), .paBus('0), .abortExec(abortExec),
    .instrRetired(instrRetired), .rtiExec(rtiExec), .bootStart(bootStart), .bootIrq(bootIrq),
    .irq(irq), .ctl(ctl), .emuInstr(emuInstr), .emuInstrValid(emuInstrValid));

  // Event watch where core outputs are settled
  always @(negedge clock)
  begin
    if (irq.emuIrq === 1'b1 && ctl.pcPush === 1'b1 && ctl.vectorReset === 1'b1)
      emuCnt++;
    if (irq.emuIrq === 1'b1 || irq.bkptIrq === 1'b1)
      lvl <= irq.level;
    if (irq.bkptIrq === 1'b1)
      bkptCnt++;
    if (ctl.flushPipe === 1'b1)
      flushCnt++;
    if (emuInstrValid === 1'b1)
      gotInstr <= emuInstr;
  end

  task automatic chk(input string n, input logic [CDB_DW-1:0] e, input logic [CDB_DW-1:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic core(input logic w, input logic [CDB_AW-1:0] a, input logic [CDB_DW-1:0] d);
    @(negedge clock);
    coreReq = '{1'b1, w, a, d};
    @(negedge clock);
    coreReq.sel = 1'b0;
    rd = coreRdata;
  endtask : core

  task automatic link(input logic w, input logic [CDB_AW-1:0] a, input logic [CDB_DW-1:0] d);
    probe.xfer(w, a, d, rd, ok);
    if (!ok)
    begin
      chk("link done", 32'h00000001, 32'h00000000);
      end_of_test();
    end
  endtask : link

  task automatic pulse(ref logic s);
    @(negedge clock);
    s = 1'b1;
    @(negedge clock);
    s = 1'b0;
  endtask : pulse

  task automatic hit(input logic [CDB_DW-1:0] a);
    @(negedge clock);
    daBus = '{1'b1, a};
    @(negedge clock);
    daBus = '{1'b0, ~a};
    repeat (3) @(negedge clock);
  endtask : hit

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  initial
  begin
    repeat (10) @(posedge clock);
    chk("reset irq", 32'h00000000, 32'(irq));
    @(negedge clock);
    rstn = 1'b1;
    foreach (rows[i])
    begin
      core(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w)
        chk("row read", rows[i].d, rd);
    end
    hit(32'h000001FF);
    chk("bkpt irqs", 32'h00000001, 32'(bkptCnt));
    chk("bkpt level", 32'h0000000C, 32'(lvl));
    core(1'b0, CDB_A_BRKSTAT, '0);
    chk("status", 32'h00000010, rd);
    hit(32'h00000200);
    chk("bkpt irqs", 32'h00000001, 32'(bkptCnt));
    pulse(rtiExec);
    core(1'b0, CDB_A_BRKSTAT, '0);
    chk("status", 32'h00000000, rd);
    core(1'b1, CDB_A_EVCNT, 32'h00000001);
    hit(32'h00000100);
    core(1'b0, CDB_A_EVCNT, '0);
    chk("event count", 32'h00000000, rd);
    chk("bkpt irqs", 32'h00000001, 32'(bkptCnt));
    hit(32'h00000100);
    chk("bkpt irqs", 32'h00000002, 32'(bkptCnt));
    core(1'b1, CDB_A_BRKCTL, 32'h0200000E);
    hit(32'h00000100);
    chk("and select", 32'h00000002, 32'(bkptCnt));
    core(1'b1, CDB_A_BRKCTL, 32'h02000102);
    hit(32'h00000200);
    chk("negate", 32'h00000003, 32'(bkptCnt));
    abortExec = 1'b1;
    hit(32'h00000200);
    abortExec = 1'b0;
    chk("abort", 32'h00000003, 32'(bkptCnt));
    core(1'b1, CDB_A_BRKCTL, 32'h00000002);
    core(1'b0, CDB_A_BRKSTAT, '0);
    chk("status", 32'h00000000, rd);
    core(1'b1, 8'h18, 32'h00000055);
    core(1'b0, 8'h18, '0);
    chk("range", 32'h00000100, rd);
    core(1'b1, CDB_A_BRKCTL, 32'h00000000);
    core(1'b0, CDB_A_CYC, '0);
    r1 = rd;
    core(1'b1, CDB_A_CYC, '0);
    core(1'b0, CDB_A_CYC, '0);
    chk("cycle delta", 32'h00000004, rd - r1);
    link(1'b0, CDB_A_CYC, '0);
    chk("link busy", 32'h00000000, 32'(jtagBusy));
    core(1'b0, CDB_A_SPC, '0);
    chk("pc sample", 32'h003C5A96, rd);
    link(1'b1, CDB_A_RCS, 32'h00000009);
    core(1'b0, CDB_A_RCS, '0);
    chk("stopped", 32'h00000001, 32'(rd[1]));
    chk("emu entries", 32'h00000001, 32'(emuCnt));
    chk("emu level", 32'h00000000, 32'(lvl));
    chk("halt ctl", 32'h0000003F, 32'({ctl.dmaStall, ctl.fetchFromEmu, ctl.timerStop, ctl.cacheDisable, ctl.pcHold,
      ctl.emuSpace}));
    core(1'b0, CDB_A_CYC, '0);
    r1 = rd;
    core(1'b0, CDB_A_CYC, '0);
    chk("cycle hold", r1, rd);
    link(1'b1, CDB_A_CYC, 32'hFFFFFFF0);
    link(1'b1, CDB_A_CYCEXT, 32'h00000005);
    core(1'b0, CDB_A_CYC, '0);
    chk("cycle load", 32'hFFFFFFF0, rd);
    link(1'b1, CDB_A_EMUINSTR, 32'hA5A5F00D);
    chk("emu instr", 32'hA5A5F00D, gotInstr);
    link(1'b1, CDB_A_RCS, 32'h00000004);
    pulse(rtiExec);
    pulse(instrRetired);
    repeat (3) @(negedge clock);
    chk("flush", 32'h00000001, 32'(flushCnt));
    chk("emu entries", 32'h00000002, 32'(emuCnt));
    link(1'b1, CDB_A_RCS, 32'h00000000);
    pulse(rtiExec);
    repeat (30) @(negedge clock);
    core(1'b0, CDB_A_CYCEXT, '0);
    chk("extension", 32'h00000006, rd);
    pulse(bootStart);
    @(negedge clock);
    chk("feed idle", 32'h00000001, 32'(ctl.feedIdle));
    pulse(bootIrq);
    @(negedge clock);
    chk("feed idle", 32'h00000000, 32'(ctl.feedIdle));
    // Mid-run reset
    pulse(bootStart);
    rstn = 1'b0;
    repeat (2) @(negedge clock);
    chk("reset ctl", 32'h00000000, 32'(ctl));
    rstn = 1'b1;
    core(1'b0, CDB_A_CYC, '0);
    chk("cycle restart", 32'h00000001, rd);
    end_of_test();
  end
endmodule : tb_top
